//--- include/dti_defines.svh
`ifndef DTI_DEFINES_SVH
`define DTI_DEFINES_SVH
// Register indices; byte address is four times the index
`define DTI_OFS_PORT_A_DATA 16'hdd00
`define DTI_OFS_PORT_B_DATA 16'hdd01
`define DTI_OFS_PORT_A_DIR 16'hdd02
`define DTI_OFS_PORT_B_DIR 16'hdd03
`define DTI_OFS_TA_LO 16'hdd04
`define DTI_OFS_TA_HI 16'hdd05
`define DTI_OFS_TB_LO 16'hdd06
`define DTI_OFS_TB_HI 16'hdd07
`define DTI_OFS_TOD_TENTHS 16'hdd08
`define DTI_OFS_TOD_SEC 16'hdd09
`define DTI_OFS_TOD_MIN 16'hdd0a
`define DTI_OFS_TOD_HOUR 16'hdd0b
`define DTI_OFS_SERIAL 16'hdd0c
`define DTI_OFS_ICR 16'hdd0d
`define DTI_OFS_CTRL_A 16'hdd0e
`define DTI_OFS_CTRL_B 16'hdd0f
`define DTI_OFS_STATUS 16'hdd10
// Interrupt source bit positions
`define DTI_IRQ_TA 0
`define DTI_IRQ_TB 1
`define DTI_IRQ_ALARM 2
`define DTI_IRQ_SERIAL 3
`define DTI_IRQ_EDGE 4
`define DTI_IRQ_ANY 7
`define DTI_ICR_SETCLR 7
// Reset values
`define DTI_RST_LATCH 16'hffff
`define DTI_RST_BYTE 8'h00
`define DTI_RST_HOUR 8'h01
// Mains cycles per tenth of a second
`define DTI_DIV_50HZ 3'h5
`define DTI_DIV_60HZ 3'h6
// Serial bits per byte
`define DTI_SER_BITS 4'h8
`define DTI_RESP_OKAY 2'h0
`define DTI_RESP_SLVERR 2'h2
`endif

//--- include/dti_pkg.sv
package dti_pkg;
  typedef enum logic [1:0] {
    DTI_SRC_PHI2,
    DTI_SRC_CNT,
    DTI_SRC_TA,
    DTI_SRC_TA_CNT
  } dti_bsrc_t;

  typedef struct packed {
    logic mains50;
    logic sp_out;
    logic src_cnt;
    logic force_ld;
    logic oneshot;
    logic toggle;
    logic pb_en;
    logic start;
  } dti_cra_t;

  typedef struct packed {
    logic alarm_wr;
    dti_bsrc_t src;
    logic force_ld;
    logic oneshot;
    logic toggle;
    logic pb_en;
    logic start;
  } dti_crb_t;

  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
    logic [7:0] tenths;
  } dti_tod_t;
endpackage

//--- rtl/dti_adapter.sv
// Contract
// - ICR read gives flags, bit 7 any; write sets or clears mask by bit 7.
// - Flag bits: 0 timer A, 1 timer B, 2 alarm, 3 serial, 4 edge.
// - Control A bit 7 picks 50 Hz or 60 Hz day-clock reference.
// - Control A bit 6 sets serial port direction, one shifts out.
// - Control A bit 5 makes timer A count count_pin or phase-2 cycles.
// - Writing one to control A bit 4 reloads timer A from latch.
// - Control A bit 3 picks one-shot or continuous timer A.
// - Control A bit 2 picks toggle or pulse on port_b_line6.
// - Control A bit 1 routes timer A output onto port_b_line6.
// - Control A bit 0 starts or stops timer A.
// - Control B bit 7 steers day-clock writes to alarm or clock.
// - Control B bits 6-5 choose timer B count source.
// - Control B bits 4-0 mirror control A functions for timer B.
// - Day clock in tenths, seconds, minutes, hours with PM in bit 7.
// - Serial buffer holds byte to send or byte received.
// - Each port has a per-bit direction register.
// - port_b_line7 carries timer B output when enabled.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "dti_defines.svh"

module dti_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire logic force_load,
  input wire logic [15:0] latch,
  output logic [15:0] count,
  output logic underflow
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  assign count = cnt_r;
  assign underflow = run && tick && !force_load && (cnt_r == 16'h0000);

  always_comb begin
    cnt_nxt = cnt_r;
    if (force_load) begin
      cnt_nxt = latch;
    end else if (underflow) begin
      cnt_nxt = latch;
    end else if (run && tick) begin
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= `DTI_RST_LATCH;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // dti_timer

module dti_adapter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  input wire logic count_pin,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic mains_ref,
  input wire logic edge_event_input,
  output logic irq
);
  // Bus state
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [15:0] waddr_r, waddr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  // Register state
  logic [7:0] pa_r, pa_nxt, pb_r, pb_nxt, da_r, da_nxt, db_r, db_nxt;
  logic [15:0] la_r, la_nxt, lb_r, lb_nxt;
  dti_pkg::dti_cra_t cra_r, cra_nxt;
  dti_pkg::dti_crb_t crb_r, crb_nxt;
  logic [4:0] mask_r, mask_nxt, flags_r, flags_nxt, ev;
  dti_pkg::dti_tod_t tod_r, tod_nxt, alarm_r, alarm_nxt;
  logic [2:0] div_r, div_nxt;
  logic [7:0] sbuf_r, sbuf_nxt, shift_r, shift_nxt;
  logic [3:0] scnt_r, scnt_nxt;
  logic sbusy_r, sbusy_nxt, sout_r, sout_nxt;
  logic cnt_d_r, mains_d_r, edge_d_r;
  logic ta_tog_r, ta_tog_nxt, tb_tog_r, tb_tog_nxt, ta_pls_r, tb_pls_r;
  logic [7:0] pb_out_r, pb_out_nxt, pb_oe_r, pb_oe_nxt;
  logic irq_r;
  // Combinational helpers
  logic cnt_rise, mains_rise, wr_go, fa, fb, ta_tick, tb_tick;
  logic [15:0] ta_cnt, tb_cnt, raddr;
  logic ta_uf, tb_uf, tenth;
  logic [7:0] hr_inc;

  assign cnt_rise = count_pin && !cnt_d_r;
  assign mains_rise = mains_ref && !mains_d_r;
  assign wr_go = aw_have_r && w_have_r && !bvalid_r;
  assign raddr = s_axi_araddr[17:2];
  assign fa = wr_go && wlane_r && waddr_r == `DTI_OFS_CTRL_A && wbyte_r[4];
  assign fb = wr_go && wlane_r && waddr_r == `DTI_OFS_CTRL_B && wbyte_r[4];
  assign ta_tick = cra_r.src_cnt ? cnt_rise : 1'b1;

  always_comb begin
    case (crb_r.src)
      dti_pkg::DTI_SRC_PHI2: tb_tick = 1'b1;
      dti_pkg::DTI_SRC_CNT: tb_tick = cnt_rise;
      dti_pkg::DTI_SRC_TA: tb_tick = ta_uf;
      default: tb_tick = ta_uf && count_pin;
    endcase
  end

  dti_timer u_ta (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .run(cra_r.start),
    .tick(ta_tick), .force_load(fa), .latch(la_r),
    .count(ta_cnt), .underflow(ta_uf)
  );

  dti_timer u_tb (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .run(crb_r.start),
    .tick(tb_tick), .force_load(fb), .latch(lb_r),
    .count(tb_cnt), .underflow(tb_uf)
  );

  // BCD step with wrap to zero past the given limit
  function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] lim);
    logic [7:0] r;
    r = 8'h00;
    if (v == lim) begin
      r = 8'h00;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  // Hour step on the bare digits; the PM bit is put back by the caller
  assign hr_inc = bcd_inc({3'h0, tod_r.hour[4:0]}, 8'h12);

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    waddr_nxt = waddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    pa_nxt = pa_r;
    pb_nxt = pb_r;
    da_nxt = da_r;
    db_nxt = db_r;
    la_nxt = la_r;
    lb_nxt = lb_r;
    cra_nxt = cra_r;
    crb_nxt = crb_r;
    mask_nxt = mask_r;
    tod_nxt = tod_r;
    alarm_nxt = alarm_r;
    div_nxt = div_r;
    sbuf_nxt = sbuf_r;
    shift_nxt = shift_r;
    scnt_nxt = scnt_r;
    sbusy_nxt = sbusy_r;
    sout_nxt = sout_r;
    ta_tog_nxt = ta_tog_r ^ ta_uf;
    tb_tog_nxt = tb_tog_r ^ tb_uf;
    ev = 5'h00;
    tenth = 1'b0;
    flags_nxt = flags_r;
    // Write channels are taken independently, in either order
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      waddr_nxt = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wbyte_nxt = s_axi_wdata[7:0];
      wlane_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Day clock paced by the mains reference
    if (mains_rise) begin
      if (div_r == (cra_r.mains50 ? `DTI_DIV_50HZ : `DTI_DIV_60HZ)) begin
        div_nxt = 3'h1;
        tenth = 1'b1;
      end else begin
        div_nxt = div_r + 3'h1;
      end
    end
    if (tenth) begin
      tod_nxt.tenths = bcd_inc(tod_r.tenths, 8'h09);
      if (tod_r.tenths == 8'h09) begin
        tod_nxt.sec = bcd_inc(tod_r.sec, 8'h59);
        if (tod_r.sec == 8'h59) begin
          tod_nxt.min = bcd_inc(tod_r.min, 8'h59);
          if (tod_r.min == 8'h59) begin
            if (tod_r.hour[4:0] == 5'h12) begin
              tod_nxt.hour = {tod_r.hour[7], 7'h01};
            end else if (tod_r.hour[4:0] == 5'h11) begin
              tod_nxt.hour = {~tod_r.hour[7], 7'h12};
            end else begin
              tod_nxt.hour = {tod_r.hour[7], hr_inc[6:0]};
            end
          end
        end
      end
    end
    // Serial shifter; output mode is clocked by timer A underflows
    if (cra_r.sp_out) begin
      if (sbusy_r && ta_uf) begin
        sout_nxt = shift_r[7];
        shift_nxt = {shift_r[6:0], 1'b0};
        scnt_nxt = scnt_r + 4'h1;
        if (scnt_r + 4'h1 == `DTI_SER_BITS) begin
          sbusy_nxt = 1'b0;
          scnt_nxt = 4'h0;
          ev[`DTI_IRQ_SERIAL] = 1'b1;
        end
      end
    end else if (cnt_rise) begin
      shift_nxt = {shift_r[6:0], serial_data_in};
      scnt_nxt = scnt_r + 4'h1;
      if (scnt_r + 4'h1 == `DTI_SER_BITS) begin
        sbuf_nxt = {shift_r[6:0], serial_data_in};
        scnt_nxt = 4'h0;
        ev[`DTI_IRQ_SERIAL] = 1'b1;
      end
    end
    // One-shot timers drop their start bit at underflow
    if (ta_uf && cra_r.oneshot) begin
      cra_nxt.start = 1'b0;
    end
    if (tb_uf && crb_r.oneshot) begin
      crb_nxt.start = 1'b0;
    end
    ev[`DTI_IRQ_TA] = ta_uf;
    ev[`DTI_IRQ_TB] = tb_uf;
    ev[`DTI_IRQ_ALARM] = tenth && (tod_nxt == alarm_r);
    ev[`DTI_IRQ_EDGE] = edge_d_r && !edge_event_input;
    // Register writes
    if (wr_go) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `DTI_RESP_OKAY;
      if (waddr_r == `DTI_OFS_PORT_A_DATA) begin
        if (wlane_r) pa_nxt = wbyte_r;
      end else if (waddr_r == `DTI_OFS_PORT_B_DATA) begin
        if (wlane_r) pb_nxt = wbyte_r;
      end else if (waddr_r == `DTI_OFS_PORT_A_DIR) begin
        if (wlane_r) da_nxt = wbyte_r;
      end else if (waddr_r == `DTI_OFS_PORT_B_DIR) begin
        if (wlane_r) db_nxt = wbyte_r;
      end else if (waddr_r == `DTI_OFS_TA_LO) begin
        if (wlane_r) la_nxt[7:0] = wbyte_r;
      end else if (waddr_r == `DTI_OFS_TA_HI) begin
        if (wlane_r) la_nxt[15:8] = wbyte_r;
      end else if (waddr_r == `DTI_OFS_TB_LO) begin
        if (wlane_r) lb_nxt[7:0] = wbyte_r;
      end else if (waddr_r == `DTI_OFS_TB_HI) begin
        if (wlane_r) lb_nxt[15:8] = wbyte_r;
      end else if (waddr_r[15:2] == `DTI_OFS_TOD_TENTHS >> 2) begin
        if (wlane_r && crb_r.alarm_wr) begin
          alarm_nxt[waddr_r[1:0]*8 +: 8] = wbyte_r;
        end else if (wlane_r) begin
          tod_nxt[waddr_r[1:0]*8 +: 8] = wbyte_r;
          div_nxt = 3'h1;
        end
      end else if (waddr_r == `DTI_OFS_SERIAL) begin
        if (wlane_r) begin
          sbuf_nxt = wbyte_r;
          if (cra_r.sp_out) begin
            shift_nxt = wbyte_r;
            sbusy_nxt = 1'b1;
            scnt_nxt = 4'h0;
          end
        end
      end else if (waddr_r == `DTI_OFS_ICR) begin
        if (wlane_r && wbyte_r[`DTI_ICR_SETCLR]) begin
          mask_nxt = mask_r | wbyte_r[4:0];
        end else if (wlane_r) begin
          mask_nxt = mask_r & ~wbyte_r[4:0];
        end
      end else if (waddr_r == `DTI_OFS_CTRL_A) begin
        if (wlane_r) begin
          cra_nxt = wbyte_r;
          cra_nxt.force_ld = 1'b0; // Strobe only, never stored
        end
      end else if (waddr_r == `DTI_OFS_CTRL_B) begin
        if (wlane_r) begin
          crb_nxt = wbyte_r;
          crb_nxt.force_ld = 1'b0;
        end
      end else if (waddr_r == `DTI_OFS_STATUS) begin
        if (wlane_r) flags_nxt = flags_r & ~wbyte_r[4:0];
      end else begin
        bresp_nxt = `DTI_RESP_SLVERR;
      end
    end
    flags_nxt = flags_nxt | ev; // New event beats a same-cycle clear
    // Reads
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = `DTI_RESP_OKAY;
      rdata_nxt = 8'h00;
      if (raddr == `DTI_OFS_PORT_A_DATA) begin
        rdata_nxt = (pa_r & da_r) | (port_a_in & ~da_r);
      end else if (raddr == `DTI_OFS_PORT_B_DATA) begin
        rdata_nxt = (pb_r & db_r) | (port_b_in & ~db_r);
      end else if (raddr == `DTI_OFS_PORT_A_DIR) begin
        rdata_nxt = da_r;
      end else if (raddr == `DTI_OFS_PORT_B_DIR) begin
        rdata_nxt = db_r;
      end else if (raddr == `DTI_OFS_TA_LO) begin
        rdata_nxt = ta_cnt[7:0];
      end else if (raddr == `DTI_OFS_TA_HI) begin
        rdata_nxt = ta_cnt[15:8];
      end else if (raddr == `DTI_OFS_TB_LO) begin
        rdata_nxt = tb_cnt[7:0];
      end else if (raddr == `DTI_OFS_TB_HI) begin
        rdata_nxt = tb_cnt[15:8];
      end else if (raddr[15:2] == `DTI_OFS_TOD_TENTHS >> 2) begin
        rdata_nxt = tod_r[raddr[1:0]*8 +: 8];
      end else if (raddr == `DTI_OFS_SERIAL) begin
        rdata_nxt = sbuf_r;
      end else if (raddr == `DTI_OFS_ICR || raddr == `DTI_OFS_STATUS) begin
        rdata_nxt = {|(flags_r & mask_r), 2'b00, flags_r};
      end else if (raddr == `DTI_OFS_CTRL_A) begin
        rdata_nxt = cra_r;
      end else if (raddr == `DTI_OFS_CTRL_B) begin
        rdata_nxt = crb_r;
      end else begin
        rresp_nxt = `DTI_RESP_SLVERR;
      end
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt = !w_have_nxt;
    // Timer lines override port B bits 6 and 7 while enabled
    pb_out_nxt = pb_r;
    pb_oe_nxt = db_r;
    if (cra_r.pb_en) begin
      pb_out_nxt[6] = cra_r.toggle ? ta_tog_r : ta_pls_r;
      pb_oe_nxt[6] = 1'b1;
    end
    if (crb_r.pb_en) begin
      pb_out_nxt[7] = crb_r.toggle ? tb_tog_r : tb_pls_r;
      pb_oe_nxt[7] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= 16'h0000;
      wbyte_r <= `DTI_RST_BYTE;
      wlane_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `DTI_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `DTI_RESP_OKAY;
      rdata_r <= `DTI_RST_BYTE;
      pa_r <= `DTI_RST_BYTE;
      pb_r <= `DTI_RST_BYTE;
      da_r <= `DTI_RST_BYTE;
      db_r <= `DTI_RST_BYTE;
      la_r <= `DTI_RST_LATCH;
      lb_r <= `DTI_RST_LATCH;
      cra_r <= '0;
      crb_r <= '0;
      mask_r <= 5'h00;
      flags_r <= 5'h00;
      tod_r <= {`DTI_RST_HOUR, 24'h00_0000};
      alarm_r <= '0;
      div_r <= 3'h1;
      sbuf_r <= `DTI_RST_BYTE;
      shift_r <= `DTI_RST_BYTE;
      scnt_r <= 4'h0;
      sbusy_r <= 1'b0;
      sout_r <= 1'b0;
      cnt_d_r <= 1'b0;
      mains_d_r <= 1'b0;
      edge_d_r <= 1'b0;
      ta_tog_r <= 1'b0;
      tb_tog_r <= 1'b0;
      ta_pls_r <= 1'b0;
      tb_pls_r <= 1'b0;
      pb_out_r <= `DTI_RST_BYTE;
      pb_oe_r <= `DTI_RST_BYTE;
      irq_r <= 1'b0;
    end else if (ce) begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      waddr_r <= waddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      pa_r <= pa_nxt;
      pb_r <= pb_nxt;
      da_r <= da_nxt;
      db_r <= db_nxt;
      la_r <= la_nxt;
      lb_r <= lb_nxt;
      cra_r <= cra_nxt;
      crb_r <= crb_nxt;
      mask_r <= mask_nxt;
      flags_r <= flags_nxt;
      tod_r <= tod_nxt;
      alarm_r <= alarm_nxt;
      div_r <= div_nxt;
      sbuf_r <= sbuf_nxt;
      shift_r <= shift_nxt;
      scnt_r <= scnt_nxt;
      sbusy_r <= sbusy_nxt;
      sout_r <= sout_nxt;
      cnt_d_r <= count_pin;
      mains_d_r <= mains_ref;
      edge_d_r <= edge_event_input;
      ta_tog_r <= ta_tog_nxt;
      tb_tog_r <= tb_tog_nxt;
      ta_pls_r <= ta_uf;
      tb_pls_r <= tb_uf;
      pb_out_r <= pb_out_nxt;
      pb_oe_r <= pb_oe_nxt;
      irq_r <= |(flags_nxt & mask_nxt);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h00_0000, rdata_r};
  assign port_a_out = pa_r;
  assign port_a_oe = da_r;
  assign port_b_out = pb_out_r;
  assign port_b_oe = pb_oe_r;
  assign serial_data_out = sout_r;
  assign serial_data_oe = cra_r.sp_out;
  assign irq = irq_r;
endmodule // dti_adapter

//--- dv/dti_host.sv
module dti_host (
  input logic aclk,
  output logic [17:0] awaddr,
  output logic awvalid,
  input logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  output logic bready,
  output logic [17:0] araddr,
  output logic arvalid,
  input logic arready,
  input logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cycles before the response is accepted; exercises slave hold
  int lag = 0;

  initial begin
    awaddr = 18'h0_0000;
    awvalid = 1'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 18'h0_0000;
    arvalid = 1'h0;
    rready = 1'h0;
  end

  // Index to byte address: offsets are not word multiples
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {a, 2'h0};
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (n == lag) bready <= 1'h1;
      n++;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {a, 2'h0};
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (n == lag) rready <= 1'h1;
      n++;
    end while (!(rvalid && rready));
    rready <= 1'h0;
  endtask
endmodule // dti_host

//--- dv/dti_adapter_asserts.sv
`include "dti_defines.svh"
module dti_adapter_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_oe,
  input wire logic serial_data_oe,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read late");
  property p_w_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write late");
  property p_slverr;
    s_axi_rvalid && s_axi_rresp == `DTI_RESP_SLVERR
      |-> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_slverr: assert property (p_slverr) else $error("refused data");
  // Only a completed write may move the port A and serial direction flops
  property p_dir;
    $past(aresetn) && !$stable(port_a_oe) |-> $rose(s_axi_bvalid);
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
  property p_ser_oe;
    $past(aresetn) && !$stable(serial_data_oe) |-> $rose(s_axi_bvalid);
  endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial dir");
  // Flags are sticky, so only a clear or mask write drops irq
  property p_irq_fall;
    $past(aresetn) && $fell(irq) |-> $rose(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  c_irq: cover property (irq);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);
  c_pb6: cover property (port_b_oe[6]);
endmodule // dti_adapter_chk

bind dti_adapter dti_adapter_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .port_a_oe(port_a_oe), .port_b_oe(port_b_oe),
  .serial_data_oe(serial_data_oe), .irq(irq));

//--- dv/dual_timer_interrupt_adapter_tb.sv
`include "dti_defines.svh"
module dual_timer_interrupt_adapter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic edge_in = 1'h1;
  logic cnt_in = 1'h0;
  logic [7:0] pa_in = 8'h00;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, w;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, sd_oe, v;
  logic [7:0] pa_out, pa_oe, pb_out, pb_oe;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'hb06d_f6d3;
  int miscompares = 0;
  int samples_checked = 0;

  always #10 aclk = ~aclk;

  dti_adapter u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_in(pa_in),
    .port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_in(8'h00),
    .port_b_out(pb_out), .port_b_oe(pb_oe), .count_pin(cnt_in),
    .serial_data_in(1'h0), .serial_data_out(), .serial_data_oe(sd_oe),
    .mains_ref(1'h0), .edge_event_input(edge_in), .irq(irq));

  dti_host u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string n, input logic [33:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rdx(input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back({`DTI_RESP_OKAY, 24'h00_0000, d});
    u_host.rd(a);
  endtask

  task automatic wrx(input logic [15:0] a, input logic [7:0] d);
    u_host.wr(a, d, 4'hf, r);
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 100; k++) begin
      if (irq === 1'h1) break;
      @(posedge aclk);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Oldest noted read result against what the slave returns
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      check("rdata", {rresp, rdata}, exp_q.pop_front());
    end
  end

  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rdx(`DTI_OFS_CTRL_A, 8'h00);
    rdx(`DTI_OFS_ICR, 8'h00);
    rdx(`DTI_OFS_TA_LO, 8'hff);
    rdx(`DTI_OFS_TOD_HOUR, `DTI_RST_HOUR);
    wrx(`DTI_OFS_CTRL_B, 8'h80);
    wrx(`DTI_OFS_TOD_HOUR, 8'h05);
    rdx(`DTI_OFS_TOD_HOUR, `DTI_RST_HOUR);
    wrx(`DTI_OFS_CTRL_B, 8'h00);
    for (int i = 0; i < 4; i++) begin
      w = xs();
      pa_in <= w[23:16];
      u_host.lag = i;
      wrx(`DTI_OFS_PORT_A_DIR, w[7:0]);
      wrx(`DTI_OFS_PORT_A_DATA, w[15:8]);
      check("port_a_oe", pa_oe, w[7:0]);
      check("port_a_out", pa_out, w[15:8]);
      rdx(`DTI_OFS_PORT_A_DIR, w[7:0]);
      rdx(`DTI_OFS_PORT_A_DATA,
          (w[15:8] & w[7:0]) | (w[23:16] & ~w[7:0]));
    end
    u_host.lag = 0;
    // No byte lane enabled: accepted but ignored
    u_host.wr(`DTI_OFS_PORT_A_DIR, 8'h00, 4'h0, r);
    check("bresp", r, `DTI_RESP_OKAY);
    rdx(`DTI_OFS_PORT_A_DIR, w[7:0]);
    exp_q.push_back({`DTI_RESP_SLVERR, 32'h0000_0000});
    u_host.rd(16'hdd20);
    wrx(`DTI_OFS_TA_LO, 8'h03);
    wrx(`DTI_OFS_TA_HI, 8'h00);
    wrx(`DTI_OFS_ICR, 8'h81);
    wrx(`DTI_OFS_CTRL_A, 8'h19);
    wait_irq();
    check("irq", irq, 1'h1);
    rdx(`DTI_OFS_ICR, 8'h81);
    rdx(`DTI_OFS_CTRL_A, 8'h08);
    rdx(`DTI_OFS_TA_LO, 8'h03);
    wrx(`DTI_OFS_STATUS, 8'h01);
    check("irq", irq, 1'h0);
    wrx(`DTI_OFS_ICR, 8'h01);
    // Timer B one-shot on timer A underflows
    wrx(`DTI_OFS_TB_LO, 8'h02);
    wrx(`DTI_OFS_TB_HI, 8'h00);
    wrx(`DTI_OFS_ICR, 8'h82);
    wrx(`DTI_OFS_CTRL_A, 8'h57);
    wrx(`DTI_OFS_CTRL_B, 8'h59);
    check("port_b_oe6", pb_oe[6], 1'h1);
    check("serial_oe", sd_oe, 1'h1);
    v = pb_out[6];
    repeat (4) @(posedge aclk);
    check("port_b_line6", pb_out[6], !v);
    wait_irq();
    check("irq", irq, 1'h1);
    wrx(`DTI_OFS_CTRL_A, 8'h00);
    rdx(`DTI_OFS_CTRL_B, 8'h48);
    wrx(`DTI_OFS_STATUS, 8'h03);
    rdx(`DTI_OFS_ICR, 8'h00);
    wrx(`DTI_OFS_ICR, 8'h90);
    edge_in <= 1'h0;
    wait_irq();
    rdx(`DTI_OFS_ICR, 8'h90);
    wrx(`DTI_OFS_STATUS, 8'h10);
    check("irq", irq, 1'h0);
    // Timer A on count_pin rises: two pulses take the count 3 to 1
    wrx(`DTI_OFS_CTRL_A, 8'h31);
    repeat (2) begin
      @(posedge aclk);
      cnt_in <= 1'h1;
      @(posedge aclk);
      cnt_in <= 1'h0;
    end
    rdx(`DTI_OFS_TA_LO, 8'h01);
    end_sim();
  end
endmodule // dual_timer_interrupt_adapter_tb
